// [lspc_counter.sv]
// Function
// - Count amplified sync pulses in a 6-bit counter while the gate is open and at the close of a timed gate.
// - Pulse count is read-only at peripheral address 04H through the data buffer.
// - On overflow the pulse count wraps to 00H and keeps counting.
// - Power-on reset and clock stop clear the pulse count to 00H.
// - Gate mode is a 2-bit register at register file address 11H, read and written.
// - Gate closed mode: gate shut, counter and gate clock halted, bias off.
// - Gate mode returns to gate closed after power-on reset and clock stop.
// - While the pin feeds the counter, the port bit reads 0, registered one cycle behind the gate mode register.
// - Entering gate open mode clears the count, then counts continuously with bias on.
// - Timed mode clears count, waits 3.375/2 ms, then opens gate 1.69 ms.
// - In timed mode an input high at gate open or close counts once.
// - Gate clock generator runs only in timed mode.
// - Gate-open flag at bit 3 of 12H is high while the gate is open.
// - In timed mode the flag goes high as soon as the mode is written.
// - Writing 0010B to the gate mode register selects timed mode.
`timescale 1ns/1ps

module lspc_counter #(
  parameter int DELAY_CYC = lspc_pkg::LSPC_DELAY_CYC,
  parameter int GATE_CYC  = lspc_pkg::LSPC_GATE_CYC
) (
  // Clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  // Clock stop reset, a level from the same clock domain
  input  wire logic                             clk_stop,
  // Sync signal on the shared pin
  input  wire logic                             sync_counter_input_pin,
  // Register file access by register_file_read_instr and register_file_write_instr
  input  wire logic                             rf_rd_en,
  input  wire logic                             rf_wr_en,
  input  wire logic [lspc_pkg::LSPC_ADDR_W-1:0]   rf_addr,
  input  wire logic [lspc_pkg::LSPC_NIBBLE_W-1:0] rf_wr_data,
  output logic      [lspc_pkg::LSPC_NIBBLE_W-1:0] rf_rd_data,
  // Peripheral read by get into the data buffer
  input  wire logic                             periph_rd_en,
  input  wire logic [lspc_pkg::LSPC_ADDR_W-1:0]   periph_addr,
  output logic      [lspc_pkg::LSPC_DBF_W-1:0]    data_buffer_register,
  // Shared port bit read value
  output logic                                  shared_port_bit,
  // Front end and status
  output logic                                  input_bias_en,
  output logic                                  gate_open_status
);
  import lspc_pkg::*;

  // Code 11 is not a documented mode; it is taken as gate closed so that
  // a stray write leaves the pin unbiased rather than counting.
  function automatic logic [1:0] lspc_decode(input logic [1:0] raw);
    case (raw)
      LSPC_MODE_OPEN:  lspc_decode = LSPC_MODE_OPEN;
      LSPC_MODE_TIMED: lspc_decode = LSPC_MODE_TIMED;
      default:         lspc_decode = LSPC_MODE_CLOSED;
    endcase
  endfunction

  // Synchronised input and edge detect.
  logic                       sync_q;
  logic                       prev_reg;
  logic                       prev_next;
  logic                       rise;

  // Mode and count state.
  logic [1:0]                 mode_reg;
  logic [1:0]                 mode_next;
  logic [LSPC_COUNT_W-1:0]    count_reg;
  logic [LSPC_COUNT_W-1:0]    count_next;
  logic                       inc;

  // Output state.
  logic                       status_reg;
  logic                       status_next;
  logic                       bias_reg;
  logic                       bias_next;
  logic                       port_reg;
  logic                       port_next;
  logic [LSPC_NIBBLE_W-1:0]   rf_rd_reg;
  logic [LSPC_NIBBLE_W-1:0]   rf_rd_next;
  logic [LSPC_DBF_W-1:0]      dbf_reg;
  logic [LSPC_DBF_W-1:0]      dbf_next;

  // Decoded controls.
  logic                       mode_wr;
  logic                       start;
  logic                       timed_start;
  logic                       timed_run;
  logic                       tm_open;
  logic                       tm_first;
  logic                       tm_end;
  logic                       tm_busy_next;

  lspc_sync u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .pin_in   (sync_counter_input_pin),
    .pin_sync (sync_q)
  );

  lspc_gate_timer #(
    .DELAY_CYC (DELAY_CYC),
    .GATE_CYC  (GATE_CYC)
  ) u_timer (
    .clk        (clk),
    .rst_b      (rst_b),
    .start      (timed_start),
    .run        (timed_run),
    .gate_open  (tm_open),
    .gate_first (tm_first),
    .gate_end   (tm_end),
    .busy_next  (tm_busy_next)
  );

  // Any write of a counting mode restarts the measurement, so software can
  // run a fresh timed gate by writing 0010B again once the flag is low.
  always_comb begin
    mode_wr     = rf_wr_en && (rf_addr == LSPC_MODE_RFADDR);
    start       = mode_wr && !clk_stop
                  && (lspc_decode(rf_wr_data[1:0]) != LSPC_MODE_CLOSED);
    timed_start = start && (lspc_decode(rf_wr_data[1:0]) == LSPC_MODE_TIMED);
    rise        = sync_q && !prev_reg;
    prev_next   = sync_q;
  end

  // Gate mode register.
  always_comb begin
    mode_next = mode_reg;
    if (clk_stop) begin
      mode_next = LSPC_MODE_RESET;
    end else if (mode_wr) begin
      mode_next = rf_wr_data[1:0];
    end
    timed_run = (lspc_decode(mode_next) == LSPC_MODE_TIMED);
  end

  // Pulse counter.
  always_comb begin
    inc = 1'b0;
    case (lspc_decode(mode_reg))
      LSPC_MODE_OPEN: begin
        inc = rise;
      end
      LSPC_MODE_TIMED: begin
        if (tm_first || tm_end) begin
          inc = sync_q;
        end else begin
          inc = tm_open && rise;
        end
      end
      default: begin
        inc = 1'b0;
      end
    endcase
    count_next = count_reg + {{(LSPC_COUNT_W-1){1'b0}}, inc};
    if (clk_stop || start) begin
      count_next = LSPC_COUNT_RESET;
    end
  end

  // Status, bias, port read value and read data.
  always_comb begin
    status_next = (lspc_decode(mode_next) == LSPC_MODE_OPEN)
                  || (timed_run && tm_busy_next);
    bias_next   = (lspc_decode(mode_next) != LSPC_MODE_CLOSED);
    port_next   = (lspc_decode(mode_reg) != LSPC_MODE_CLOSED) ? 1'b0 : sync_q;
    rf_rd_next  = rf_rd_reg;
    if (rf_rd_en) begin
      case (rf_addr)
        LSPC_MODE_RFADDR: begin
          rf_rd_next = {2'h0, mode_reg};
        end
        LSPC_STATUS_RFADDR: begin
          rf_rd_next = '0;
          rf_rd_next[LSPC_STATUS_BIT] = status_reg;
        end
        default: begin
          rf_rd_next = '0;
        end
      endcase
    end
    dbf_next = dbf_reg;
    if (periph_rd_en && (periph_addr == LSPC_COUNT_PADDR)) begin
      dbf_next = {{(LSPC_DBF_W-LSPC_COUNT_W){1'b0}}, count_reg};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg   <= 1'b0;
      mode_reg   <= LSPC_MODE_RESET;
      count_reg  <= LSPC_COUNT_RESET;
      status_reg <= 1'b0;
      bias_reg   <= 1'b0;
      port_reg   <= 1'b0;
      rf_rd_reg  <= '0;
      dbf_reg    <= '0;
    end else begin
      prev_reg   <= prev_next;
      mode_reg   <= mode_next;
      count_reg  <= count_next;
      status_reg <= status_next;
      bias_reg   <= bias_next;
      port_reg   <= port_next;
      rf_rd_reg  <= rf_rd_next;
      dbf_reg    <= dbf_next;
    end
  end

  assign rf_rd_data           = rf_rd_reg;
  assign data_buffer_register = dbf_reg;
  assign shared_port_bit      = port_reg;
  assign input_bias_en        = bias_reg;
  assign gate_open_status     = status_reg;

  property p_closed_hold;
    @(posedge clk) disable iff (!rst_b)
      (lspc_decode(mode_reg) == LSPC_MODE_CLOSED) && !start && !clk_stop
        |=> (count_reg == $past(count_reg));
  endproperty
  a_closed_hold: assert property (p_closed_hold) else $error("Count moved while closed.");

  property p_gate_only;
    @(posedge clk) disable iff (!rst_b)
      (lspc_decode(mode_reg) == LSPC_MODE_TIMED) && !tm_open && !tm_end
        && !start && !clk_stop |=> (count_reg == $past(count_reg));
  endproperty
  a_gate_only: assert property (p_gate_only) else $error("Count moved with gate shut.");

  property p_wrap;
    @(posedge clk) disable iff (!rst_b)
      (count_reg == 6'h3F) && inc && !start && !clk_stop |=> (count_reg == LSPC_COUNT_RESET);
  endproperty
  a_wrap: assert property (p_wrap) else $error("Count did not wrap.");

  property p_stop_clear;
    @(posedge clk) disable iff (!rst_b)
      clk_stop |=> (count_reg == LSPC_COUNT_RESET) && (mode_reg == LSPC_MODE_CLOSED)
                   && !input_bias_en && !gate_open_status;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("Clock stop did not reset.");

  property p_mode_rw;
    @(posedge clk) disable iff (!rst_b)
      mode_wr && !clk_stop ##1 !mode_wr && !clk_stop
        ##1 (rf_rd_en && (rf_addr == LSPC_MODE_RFADDR) && !mode_wr)
        |=> (rf_rd_data == {2'h0, $past(rf_wr_data[1:0], 3)});
  endproperty
  a_mode_rw: assert property (p_mode_rw) else $error("Mode readback wrong.");

  property p_bias;
    @(posedge clk) disable iff (!rst_b)
      input_bias_en == (lspc_decode(mode_reg) != LSPC_MODE_CLOSED);
  endproperty
  a_bias: assert property (p_bias) else $error("Bias does not follow mode.");

  property p_port_zero;
    @(posedge clk) disable iff (!rst_b)
      (lspc_decode(mode_reg) != LSPC_MODE_CLOSED) |=> !shared_port_bit;
  endproperty
  a_port_zero: assert property (p_port_zero) else $error("Port bit not zero.");

  property p_start_clear;
    @(posedge clk) disable iff (!rst_b)
      start |=> (count_reg == LSPC_COUNT_RESET);
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("Count not cleared on entry.");

  property p_edge_count;
    @(posedge clk) disable iff (!rst_b)
      (lspc_decode(mode_reg) == LSPC_MODE_TIMED) && (tm_first || tm_end) && sync_q
        && !start && !clk_stop |=> (count_reg == $past(count_reg) + 6'h01);
  endproperty
  a_edge_count: assert property (p_edge_count) else $error("High level at gate edge missed.");

  property p_status_write;
    @(posedge clk) disable iff (!rst_b)
      timed_start |=> gate_open_status && !tm_open;
  endproperty
  a_status_write: assert property (p_status_write) else $error("Flag late on mode write.");

  property p_status_close;
    @(posedge clk) disable iff (!rst_b)
      tm_end && (lspc_decode(mode_reg) == LSPC_MODE_TIMED) && !mode_wr && !clk_stop
        |-> !gate_open_status;
  endproperty
  a_status_close: assert property (p_status_close) else $error("Flag high after close.");

  property p_status_rd;
    @(posedge clk) disable iff (!rst_b)
      rf_rd_en && (rf_addr == LSPC_STATUS_RFADDR)
        |=> (rf_rd_data == {$past(status_reg), 3'h0});
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("Status read wrong.");

  property p_count_rd;
    @(posedge clk) disable iff (!rst_b)
      periph_rd_en && (periph_addr == LSPC_COUNT_PADDR)
        |=> (data_buffer_register == {10'h000, $past(count_reg)});
  endproperty
  a_count_rd: assert property (p_count_rd) else $error("Count read wrong.");

  property p_open_decode;
    @(posedge clk) disable iff (!rst_b)
      mode_wr && !clk_stop && (rf_wr_data[1:0] == LSPC_MODE_OPEN) |=> gate_open_status;
  endproperty
  a_open_decode: assert property (p_open_decode) else $error("Code 01 did not open gate.");
endmodule

// [lspc_parts.sv]
`timescale 1ns/1ps

module lspc_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Asynchronous level in, synchronised level out
  input  wire logic pin_in,
  output logic      pin_sync
);
  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync = sync_reg;
endmodule

module lspc_gate_timer #(
  parameter int DELAY_CYC = lspc_pkg::LSPC_DELAY_CYC,
  parameter int GATE_CYC  = lspc_pkg::LSPC_GATE_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Control from the gate mode logic
  input  wire logic start,
  input  wire logic run,
  // Gate state
  output logic      gate_open,
  output logic      gate_first,
  output logic      gate_end,
  output logic      busy_next
);
  import lspc_pkg::*;

  localparam int CW = $clog2((DELAY_CYC > GATE_CYC ? DELAY_CYC : GATE_CYC) + 1);

  lspc_tm_state_type state_reg;
  lspc_tm_state_type state_next;
  logic [CW-1:0]     cnt_reg;
  logic [CW-1:0]     cnt_next;
  logic              end_reg;
  logic              end_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    end_next   = 1'b0;
    if (!run) begin
      state_next = LSPC_TM_IDLE;
      cnt_next   = '0;
    end else if (start) begin
      state_next = LSPC_TM_WAIT;
      cnt_next   = '0;
    end else begin
      case (state_reg)
        LSPC_TM_WAIT: begin
          if (cnt_reg == CW'(DELAY_CYC - 1)) begin
            state_next = LSPC_TM_OPEN;
            cnt_next   = '0;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        LSPC_TM_OPEN: begin
          if (cnt_reg == CW'(GATE_CYC - 1)) begin
            state_next = LSPC_TM_IDLE;
            cnt_next   = '0;
            end_next   = 1'b1;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= LSPC_TM_IDLE;
      cnt_reg   <= '0;
      end_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      end_reg   <= end_next;
    end
  end

  assign gate_open  = (state_reg == LSPC_TM_OPEN);
  assign gate_first = gate_open && (cnt_reg == '0);
  assign gate_end   = end_reg;
  assign busy_next  = (state_next != LSPC_TM_IDLE);

  property p_gate_delay;
    @(posedge clk) disable iff (!rst_b)
      $rose(gate_open) |-> ($past(state_reg) == LSPC_TM_WAIT)
                           && ($past(cnt_reg) == CW'(DELAY_CYC - 1));
  endproperty
  a_gate_delay: assert property (p_gate_delay) else $error("Gate opened early.");

  property p_gate_len;
    @(posedge clk) disable iff (!rst_b)
      gate_end |-> $past(gate_open) && ($past(cnt_reg) == CW'(GATE_CYC - 1));
  endproperty
  a_gate_len: assert property (p_gate_len) else $error("Gate length wrong.");

  property p_idle_halt;
    @(posedge clk) disable iff (!rst_b)
      !run |=> (state_reg == LSPC_TM_IDLE) && !gate_open;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("Gate clock ran outside timed mode.");
endmodule

// [lspc_pkg.sv]
package lspc_pkg;

  // Register map of the block.
  localparam logic [6:0]  LSPC_COUNT_PADDR    = 7'h04;
  localparam logic [6:0]  LSPC_MODE_RFADDR    = 7'h11;
  localparam logic [6:0]  LSPC_STATUS_RFADDR  = 7'h12;
  localparam int          LSPC_STATUS_BIT     = 3;

  // Widths of the data paths.
  localparam int          LSPC_COUNT_W        = 6;
  localparam int          LSPC_NIBBLE_W       = 4;
  localparam int          LSPC_DBF_W          = 16;
  localparam int          LSPC_ADDR_W         = 7;

  // Values after reset.
  localparam logic [5:0]  LSPC_COUNT_RESET    = 6'h00;
  localparam logic [1:0]  LSPC_MODE_RESET     = 2'h0;

  // Gate mode codes.
  localparam logic [1:0]  LSPC_MODE_CLOSED    = 2'h0;
  localparam logic [1:0]  LSPC_MODE_OPEN      = 2'h1;
  localparam logic [1:0]  LSPC_MODE_TIMED     = 2'h2;

  // Timing of the timed gate, in ns, at a 25 ns clock.
  localparam int          LSPC_CLK_NS         = 25;
  localparam int          LSPC_DELAY_NS       = 3375000 / 2;
  localparam int          LSPC_GATE_NS        = 1690000;
  localparam int          LSPC_DELAY_CYC      = (LSPC_DELAY_NS + LSPC_CLK_NS - 1) / LSPC_CLK_NS;
  localparam int          LSPC_GATE_CYC       = (LSPC_GATE_NS + LSPC_CLK_NS - 1) / LSPC_CLK_NS;

  // Gate clock generator states.
  typedef enum logic [1:0] {
    LSPC_TM_IDLE,
    LSPC_TM_WAIT,
    LSPC_TM_OPEN
  } lspc_tm_state_type;

endpackage

// [lspc_sync_source.sv]
`timescale 1ns/1ps

module lspc_sync_source (
  // Clock
  input  wire logic clk,
  // Sync level driven onto the shared pin
  output logic      sync_counter_input_pin
);
  initial begin
    sync_counter_input_pin = 1'b0;
  end

  // Called just after a rising edge. High and low times of two cycles or more
  // keep every edge visible through the two-flop synchroniser of the device.
  task automatic send(input int n, input int hi, input int lo);
    repeat (n) begin
      sync_counter_input_pin <= 1'b1;
      repeat (hi) @(posedge clk);
      sync_counter_input_pin <= 1'b0;
      repeat (lo) @(posedge clk);
    end
  endtask

  task automatic level(input logic v);
    sync_counter_input_pin <= v;
    @(posedge clk);
  endtask
endmodule

// [tb_line_sync_pulse_counter.sv]
`timescale 1ns/1ps

module tb_line_sync_pulse_counter;
  import lspc_pkg::*;

  // Short gate timing keeps the run brief.
  localparam int DLY = 24;
  localparam int GT  = 60;

  logic        clk;
  logic        rst_b;
  logic        clk_stop;
  logic        pin;
  logic        rf_rd_en;
  logic        rf_wr_en;
  logic [6:0]  rf_addr;
  logic [3:0]  rf_wr_data;
  logic [3:0]  rf_rd_data;
  logic        periph_rd_en;
  logic [6:0]  periph_addr;
  logic [6:0]  ga;
  logic [15:0] dbf;
  logic        port_bit;
  logic        bias;
  logic        status;
  logic        rd_seen;
  logic        gt_seen;
  logic        on;
  logic [15:0] rd_q[$];
  logic [15:0] gt_q[$];
  int          n_errors;
  int          num_checks;
  integer      seed;
  int          n;
  int          hi;
  int          lo;
  int          t;

  lspc_counter #(
    .DELAY_CYC (DLY),
    .GATE_CYC  (GT)
  ) i_dut (
    .clk                    (clk),
    .rst_b                  (rst_b),
    .clk_stop               (clk_stop),
    .sync_counter_input_pin (pin),
    .rf_rd_en               (rf_rd_en),
    .rf_wr_en               (rf_wr_en),
    .rf_addr                (rf_addr),
    .rf_wr_data             (rf_wr_data),
    .rf_rd_data             (rf_rd_data),
    .periph_rd_en           (periph_rd_en),
    .periph_addr            (periph_addr),
    .data_buffer_register   (dbf),
    .shared_port_bit        (port_bit),
    .input_bias_en          (bias),
    .gate_open_status       (status)
  );

  lspc_sync_source i_src (
    .clk                    (clk),
    .sync_counter_input_pin (pin)
  );

  always #12.5 clk = ~clk;

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chb(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask

  task automatic register_file_write_instr(input logic [6:0] a, input logic [3:0] d);
    rf_wr_en <= 1'b1;
    rf_addr <= a;
    rf_wr_data <= d;
    @(posedge clk);
    rf_wr_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic register_file_read_instr(input logic [6:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    rf_rd_en <= 1'b1;
    rf_addr <= a;
    @(posedge clk);
    rf_rd_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic peripheral_read_instr(input logic [15:0] e);
    gt_q.push_back(e);
    periph_rd_en <= 1'b1;
    periph_addr <= ga;
    @(posedge clk);
    periph_rd_en <= 1'b0;
    @(posedge clk);
  endtask

  // Bounded poll of the gate flag, as software would do before reading.
  task automatic wait_closed;
    t = 0;
    while (status === 1'b1 && t < 500) begin
      @(posedge clk);
      t++;
    end
    chb("gate_open_status", 1'b0, status);
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    rd_seen <= rf_rd_en;
    gt_seen <= periph_rd_en;
  end

  always @(negedge clk) begin
    if (rd_seen) begin
      chk("rf_rd_data", rd_q.pop_front(), {12'h000, rf_rd_data});
    end
    if (gt_seen) begin
      chk("data_buffer_register", gt_q.pop_front(), dbf);
    end
  end

  initial begin
    repeat (4000) @(posedge clk);
    n_errors++;
    summarize();
  end

  initial begin
    seed = 702;
    clk = 1'b0;
    rst_b = 1'b0;
    clk_stop = 1'b0;
    rf_rd_en = 1'b0;
    rf_wr_en = 1'b0;
    rf_addr = 7'h00;
    rf_wr_data = 4'h0;
    periph_rd_en = 1'b0;
    periph_addr = 7'h00;
    ga = LSPC_COUNT_PADDR;
    rd_seen = 1'b0;
    gt_seen = 1'b0;
    n_errors = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chb("input_bias_en", 1'b0, bias);
    register_file_read_instr(LSPC_MODE_RFADDR, 16'h0000);
    register_file_read_instr(LSPC_STATUS_RFADDR, 16'h0000);
    register_file_read_instr(7'h13, 16'h0000);
    peripheral_read_instr(16'h0000);
    for (int m = 0; m < 4; m++) begin
      on = (m == 1 || m == 2);
      register_file_write_instr(LSPC_MODE_RFADDR, {2'($random(seed)), 2'(m)});
      chb("input_bias_en", on, bias);
      chb("gate_open_status", on, status);
      register_file_read_instr(LSPC_MODE_RFADDR, 16'(m));
    end
    register_file_write_instr(7'h10, 4'h1);
    register_file_read_instr(LSPC_MODE_RFADDR, 16'h0003);
    n = 60 + {$random(seed)} % 10;
    hi = 2 + {$random(seed)} % 3;
    lo = 2 + {$random(seed)} % 3;
    register_file_write_instr(LSPC_MODE_RFADDR, 4'h1);
    i_src.level(1'b1);
    repeat (3) @(posedge clk);
    chb("shared_port_bit", 1'b0, port_bit);
    i_src.level(1'b0);
    i_src.send(n - 1, hi, lo);
    repeat (2) @(posedge clk);
    peripheral_read_instr(16'(n % 64));
    chb("gate_open_status", 1'b1, status);
    register_file_write_instr(LSPC_MODE_RFADDR, 4'h0);
    i_src.send(5, 2, 2);
    repeat (2) @(posedge clk);
    peripheral_read_instr(16'(n % 64));
    chb("input_bias_en", 1'b0, bias);
    chb("gate_open_status", 1'b0, status);
    i_src.level(1'b1);
    repeat (3) @(posedge clk);
    chb("shared_port_bit", 1'b1, port_bit);
    i_src.level(1'b0);
    register_file_write_instr(LSPC_MODE_RFADDR, 4'h1);
    peripheral_read_instr(16'h0000);
    i_src.send(3, hi, lo);
    repeat (2) @(posedge clk);
    // A get of any other address must leave the buffer at the earlier zero.
    ga = LSPC_COUNT_PADDR ^ 7'(1 + {$random(seed)} % 127);
    peripheral_read_instr(16'h0000);
    ga = LSPC_COUNT_PADDR;
    peripheral_read_instr(16'h0003);
    clk_stop <= 1'b1;
    @(posedge clk);
    clk_stop <= 1'b0;
    @(posedge clk);
    peripheral_read_instr(16'h0000);
    register_file_read_instr(LSPC_MODE_RFADDR, 16'h0000);
    chb("input_bias_en", 1'b0, bias);
    // A level held high across both gate edges counts once at each edge.
    i_src.level(1'b1);
    repeat (3) @(posedge clk);
    register_file_write_instr(LSPC_MODE_RFADDR, 4'h2);
    chb("gate_open_status", 1'b1, status);
    chb("input_bias_en", 1'b1, bias);
    wait_closed();
    chb("gate_span", 1'b1, t >= DLY + GT && t <= DLY + GT + 2);
    i_src.level(1'b0);
    register_file_read_instr(LSPC_STATUS_RFADDR, 16'h0000);
    peripheral_read_instr(16'h0002);
    // Pulses in the delay are ignored, pulses inside the gate are counted.
    n = 1 + {$random(seed)} % 6;
    register_file_write_instr(LSPC_MODE_RFADDR, 4'h2);
    i_src.send(3, 2, 2);
    repeat (DLY - 8) @(posedge clk);
    i_src.send(n, hi, lo);
    wait_closed();
    peripheral_read_instr(16'(n));
    summarize();
  end
endmodule
